// ===== hdl/sps_pkg.sv
// Package for the strap pin sampler: register map, strap layout and reset values
package sps_pkg;
	// Strap bit positions inside the captured vector
	localparam int STRAP_W = 5;
	localparam int POS_SUPPLY = 0;
	localparam int POS_BOOT_A = 1;
	localparam int POS_BOOT_B = 2;
	localparam int POS_LOG = 3;
	localparam int POS_EDGE = 4;
	// Internal weak pull levels: supply down, boot A up, boot B down, log up, edge up
	localparam logic [4:0] PULL_LEVEL = 5'h1A;
	// Register byte addresses
	localparam logic [3:0] ADDR_W = 4'h4;
	localparam logic [3:0] OFS_STRAP = 4'h0;
	localparam logic [3:0] OFS_OVR = 4'h4;
	localparam logic [3:0] OFS_EFFECT = 4'h8;
	localparam logic [3:0] OFS_ID = 4'hC;
	// Override register field positions
	localparam int OVR_SUPPLY_EN = 0;
	localparam int OVR_SUPPLY_VAL = 1;
	localparam int OVR_EDGE_EN = 2;
	localparam int OVR_IN_EDGE = 3;
	localparam int OVR_OUT_EDGE = 4;
	localparam logic [4:0] OVR_RESET = 5'h00;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
	// Identity word, value is arbitrary
	localparam logic [31:0] BLOCK_ID = 32'h5350_0001;
	// Boot mode encodings
	typedef enum logic [1:0] {
		SPS_BOOT_FLASH = 2'h0,
		SPS_BOOT_DOWNLOAD = 2'h1,
		SPS_BOOT_UNDEFINED = 2'h2
	} sps_boot_t;
	// Selections handed to the rest of the chip
	typedef struct packed {
		logic supply_1v8;
		logic uart_log_on;
		logic sdio_in_rising;
		logic sdio_out_rising;
	} sps_sel_t;
	// Sequencing states, one-hot
	typedef enum logic [2:0] {
		SPS_ST_RESET = 3'h1,
		SPS_ST_CAPTURE = 3'h2,
		SPS_ST_RUN = 3'h4
	} sps_state_t;
endpackage : sps_pkg

// ===== hdl/sps_strap_sampler.sv
// Strap pin sampler: captures five straps during power-on reset and exposes them over Avalon-MM
`timescale 1ns/1ps
// Notes on behaviour
// - While power-on reset is held, each strap level is sampled as a 0 or 1.
// - Captured straps stay fixed until power loss; later pin activity is ignored.
// - A readable register returns all five captured strap bits.
// - During reset each strap pin gets its own weak pull-up or pull-down.
// - An open or high-impedance strap captures the level of its internal pull.
// - After reset the pins return to normal use and straps no longer touch them.
// - Supply strap pulls down; 0 selects 3.3V, 1 selects 1.8V.
// - Boot A high gives flash boot; both low gives download; log strap enables UART log.
// - Log strap picks SDIO input edge, edge strap picks output edge; 1 means rising.
// - Firmware may override supply voltage and SDIO edge selections through registers.
// - Chip enable is active high; the device stays disabled while it is low.
module sps_strap_sampler
	import sps_pkg::*;
(
	// Clock and reset
	input wire logic CLK_SYS_IN,
	input wire logic RST_IN,
	// Chip enable and power-on reset
	input wire logic CHIP_EN_IN,
	input wire logic POR_IN,
	// Strap pins: level seen, pad pull request
	input wire logic [4:0] STRAP_PIN_IN,
	input wire logic [4:0] STRAP_PIN_DRIVEN_IN,
	output logic [4:0] STRAP_PULL_EN_OUT,
	output logic [4:0] STRAP_PULL_UP_OUT,
	output logic PIN_FUNCTIONAL_OUT,
	// Selections to the rest of the chip
	output logic CHIP_RUN_OUT,
	output logic SUPPLY_1V8_OUT,
	output logic [1:0] BOOT_MODE_OUT,
	output logic UART_LOG_EN_OUT,
	output logic SDIO_IN_RISING_OUT,
	output logic SDIO_OUT_RISING_OUT,
	// Avalon-MM slave
	input wire logic [3:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	input wire logic [3:0] AVS_BYTEENABLE_IN,
	output logic [31:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT
);
	sps_state_t state;
	sps_state_t next_state;
	logic [4:0] strap;
	logic [4:0] sample;
	logic [4:0] ovr;
	logic captured;
	sps_sel_t sel;
	sps_boot_t boot;
	logic bus_req;
	logic ack;

	// Pad level, or the weak pull when nothing outside drives the pin
	function automatic logic [4:0] pad_level(input logic [4:0] lvl, input logic [4:0] drv);
		pad_level = (lvl & drv) | (PULL_LEVEL & ~drv);
	endfunction : pad_level

	// Register read mux, used by the read path
	function automatic logic [31:0] reg_read(input logic [3:0] a, input logic [4:0] s,
		input logic [4:0] o, input sps_sel_t e, input sps_boot_t b, input logic c);
		case (a)
			OFS_STRAP: reg_read = {26'h0, c, s};
			OFS_OVR: reg_read = {27'h0, o};
			OFS_EFFECT: reg_read = {26'h0, b, e};
			OFS_ID: reg_read = BLOCK_ID;
			default: reg_read = UNMAPPED_READ;
		endcase
	endfunction : reg_read

	assign sample = pad_level(STRAP_PIN_IN, STRAP_PIN_DRIVEN_IN);

	// Sequencing: reset or disabled, capture while POR held, then run
	always_comb begin
		next_state = state;
		case (state)
			SPS_ST_RESET: begin
				if (CHIP_EN_IN && POR_IN) begin
					next_state = SPS_ST_CAPTURE;
				end
			end
			SPS_ST_CAPTURE: begin
				if (!CHIP_EN_IN) begin
					next_state = SPS_ST_RESET;
				end else if (!POR_IN) begin
					next_state = SPS_ST_RUN;
				end
			end
			SPS_ST_RUN: begin
				if (!CHIP_EN_IN) begin
					next_state = SPS_ST_RESET;
				end
			end
			default: next_state = SPS_ST_RESET;
		endcase
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			state <= SPS_ST_RESET;
		end else begin
			state <= next_state;
		end
	end

	// Strap latches track the pins only while POR is held; frozen once captured
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			strap <= PULL_LEVEL;
			captured <= 1'b0;
		end else if (state == SPS_ST_CAPTURE && POR_IN && !captured) begin
			strap <= sample;
		end else if (state == SPS_ST_CAPTURE && !POR_IN) begin
			captured <= 1'b1;
		end else if (state == SPS_ST_RESET) begin
			// Chip enable loss counts as power loss: allow a fresh capture
			captured <= 1'b0;
		end
	end

	// Weak pulls applied only while in reset; released for normal pin use after
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			STRAP_PULL_EN_OUT <= 5'h1F;
			STRAP_PULL_UP_OUT <= PULL_LEVEL;
			PIN_FUNCTIONAL_OUT <= 1'b0;
		end else begin
			STRAP_PULL_EN_OUT <= (next_state == SPS_ST_RUN) ? 5'h00 : 5'h1F;
			STRAP_PULL_UP_OUT <= PULL_LEVEL;
			PIN_FUNCTIONAL_OUT <= (next_state == SPS_ST_RUN);
		end
	end

	// Firmware override register
	assign bus_req = (AVS_READ_IN || AVS_WRITE_IN) && !ack;
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			ovr <= OVR_RESET;
		end else if (AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == OFS_OVR && AVS_BYTEENABLE_IN[0]) begin
			ovr <= AVS_WRITEDATA_IN[4:0];
		end
	end

	// Effective selections: strap decode, then override where enabled
	always_comb begin
		sel.supply_1v8 = ovr[OVR_SUPPLY_EN] ? ovr[OVR_SUPPLY_VAL] : strap[POS_SUPPLY];
		sel.uart_log_on = strap[POS_LOG];
		sel.sdio_in_rising = ovr[OVR_EDGE_EN] ? ovr[OVR_IN_EDGE] : strap[POS_LOG];
		sel.sdio_out_rising = ovr[OVR_EDGE_EN] ? ovr[OVR_OUT_EDGE] : strap[POS_EDGE];
		if (strap[POS_BOOT_A]) begin
			boot = SPS_BOOT_FLASH;
		end else if (!strap[POS_BOOT_B]) begin
			boot = SPS_BOOT_DOWNLOAD;
		end else begin
			boot = SPS_BOOT_UNDEFINED;
		end
	end

	// Selections registered out; chip held off while disabled
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			CHIP_RUN_OUT <= 1'b0;
			SUPPLY_1V8_OUT <= PULL_LEVEL[POS_SUPPLY];
			BOOT_MODE_OUT <= SPS_BOOT_FLASH;
			UART_LOG_EN_OUT <= PULL_LEVEL[POS_LOG];
			SDIO_IN_RISING_OUT <= PULL_LEVEL[POS_LOG];
			SDIO_OUT_RISING_OUT <= PULL_LEVEL[POS_EDGE];
		end else begin
			CHIP_RUN_OUT <= (state == SPS_ST_RUN) && CHIP_EN_IN;
			SUPPLY_1V8_OUT <= sel.supply_1v8;
			BOOT_MODE_OUT <= boot;
			UART_LOG_EN_OUT <= sel.uart_log_on;
			SDIO_IN_RISING_OUT <= sel.sdio_in_rising;
			SDIO_OUT_RISING_OUT <= sel.sdio_out_rising;
		end
	end

	// Bus answer: waitrequest high except the one cycle that completes a request
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			ack <= 1'b0;
			AVS_WAITREQUEST_OUT <= 1'b1;
			AVS_READDATA_OUT <= 32'h0000_0000;
		end else begin
			ack <= bus_req;
			AVS_WAITREQUEST_OUT <= !bus_req;
			if (bus_req && AVS_READ_IN) begin
				AVS_READDATA_OUT <= reg_read(AVS_ADDRESS_IN, strap, ovr, sel, boot, captured);
			end
		end
	end
endmodule : sps_strap_sampler

// ===== bench/sps_board_model.sv
// Board side of the straps: resistor or GPIO per pin
`timescale 1ns/1ps
module sps_board_model (
	input wire logic [4:0] drive_in,
	input wire logic [4:0] level_in,
	input wire logic [4:0] pull_en_in,
	input wire logic [4:0] pull_up_in,
	output logic [4:0] pin_out
);
	// Unpulled open pin shows the inverse, never a stale level
	assign pin_out = drive_in & level_in | ~drive_in & (pull_en_in & pull_up_in | ~pull_en_in & ~level_in);
endmodule : sps_board_model

// ===== bench/sps_checker.sv
// Port assertions for the strap sampler
`timescale 1ns/1ps
module sps_checker
	import sps_pkg::*;
(
	input wire logic CLK_SYS_IN,
	input wire logic RST_IN,
	input wire logic CHIP_EN_IN,
	input wire logic POR_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WAITREQUEST_OUT,
	input wire logic [4:0] STRAP_PULL_EN_OUT,
	input wire logic PIN_FUNCTIONAL_OUT,
	input wire logic CHIP_RUN_OUT,
	input wire logic [1:0] BOOT_MODE_OUT
);
	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (RST_IN);
	sequence por_drop;
		$fell(POR_IN) ##0 CHIP_EN_IN && !PIN_FUNCTIONAL_OUT;
	endsequence
	AST_RUN_GATE: assert property (!CHIP_EN_IN |=> !CHIP_RUN_OUT) else $error("run gate");
	AST_RUN_ROSE: assert property ($rose(CHIP_RUN_OUT) |-> PIN_FUNCTIONAL_OUT) else $error("run rise");
	AST_PULL_ON: assert property (!PIN_FUNCTIONAL_OUT |-> STRAP_PULL_EN_OUT == 5'h1F) else $error("pull on");
	AST_PULL_OFF: assert property (PIN_FUNCTIONAL_OUT |-> STRAP_PULL_EN_OUT == 5'h00) else $error("pull off");
	AST_FINAL: assert property (por_drop |=> PIN_FUNCTIONAL_OUT) else $error("release");
	AST_HOLD: assert property (PIN_FUNCTIONAL_OUT && $past(PIN_FUNCTIONAL_OUT) && CHIP_EN_IN
		|=> $stable(BOOT_MODE_OUT)) else $error("hold");
	AST_ANSWER: assert property (AVS_READ_IN && AVS_WAITREQUEST_OUT |-> ##[1:2] !AVS_WAITREQUEST_OUT) else $error("ans");
	AST_ONE_WAIT: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT) else $error("wait");
endmodule : sps_checker
bind sps_strap_sampler sps_checker sps_checker_inst (.CLK_SYS_IN(CLK_SYS_IN), .RST_IN(RST_IN), .CHIP_EN_IN(CHIP_EN_IN),
	.POR_IN(POR_IN), .AVS_READ_IN(AVS_READ_IN), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
	.STRAP_PULL_EN_OUT(STRAP_PULL_EN_OUT), .PIN_FUNCTIONAL_OUT(PIN_FUNCTIONAL_OUT), .CHIP_RUN_OUT(CHIP_RUN_OUT),
	.BOOT_MODE_OUT(BOOT_MODE_OUT));

// ===== bench/testbench.sv
// Strap sampler bench with reference model
`timescale 1ns/1ps
module testbench;
	import sps_pkg::*;
	logic clk = 0, rst = 1, en = 0, por = 0, rd = 0, wr = 0, fn, run, v18, lg, si, so, wq;
	logic [4:0] de = 0, lv = 0, pin, pe, pu, s;
	logic [3:0] ad = 0;
	logic [31:0] wd = 0, rdat, q;
	logic [1:0] bm;
	logic [5:0] sel;
	int fails = 0, compares = 0, seed = 32'h3DA37459;
	always #12.5 clk = ~clk;
	sps_board_model sps_board_model_inst (.drive_in(de), .level_in(lv), .pull_en_in(pe), .pull_up_in(pu), .pin_out(pin));
	sps_strap_sampler sps_strap_sampler_inst (.CLK_SYS_IN(clk), .RST_IN(rst), .CHIP_EN_IN(en), .POR_IN(por),
		.STRAP_PIN_IN(pin), .STRAP_PIN_DRIVEN_IN(de), .STRAP_PULL_EN_OUT(pe), .STRAP_PULL_UP_OUT(pu),
		.PIN_FUNCTIONAL_OUT(fn), .CHIP_RUN_OUT(run), .SUPPLY_1V8_OUT(v18), .BOOT_MODE_OUT(bm),
		.UART_LOG_EN_OUT(lg), .SDIO_IN_RISING_OUT(si), .SDIO_OUT_RISING_OUT(so), .AVS_ADDRESS_IN(ad),
		.AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(4'hF),
		.AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wq));
	task automatic chk(input logic [31:0] v, input logic [31:0] e);
		compares++;
		if (v !== e) begin
			fails++;
			$display("unexpected at %0t: %h not %h", $time, v, e);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		rd <= !w;
		wr <= w;
		ad <= a;
		wd <= d;
		do @(posedge clk); while (wq !== 1'b0 && ++n < 40);
		q = rdat;
		fails += int'(n >= 40);
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic boot(input logic [4:0] d, input logic [4:0] l);
		en <= 1'b0;
		repeat (2) @(posedge clk);
		chk(run, 0);
		de <= d;
		lv <= l;
		en <= 1'b1;
		por <= 1'b1;
		repeat (3) @(posedge clk);
		chk({pe, pu}, {5'h1F, PULL_LEVEL});
		por <= 1'b0;
		repeat (3) @(posedge clk);
		// Pins reused as ordinary I/O
		de <= 5'h1F;
		lv <= ~l;
		s = d & l | ~d & PULL_LEVEL;
		sel = {s[POS_BOOT_A] ? 2'h0 : {s[POS_BOOT_B], !s[POS_BOOT_B]}, s[POS_SUPPLY], s[POS_LOG], s[POS_LOG], s[POS_EDGE]};
		repeat (2) @(posedge clk);
		chk({run, fn, pe}, 7'h60);
		chk({bm, v18, lg, si, so}, sel);
		bus(0, OFS_STRAP, 0);
		chk(q, {26'h0, 1'b1, s});
		bus(0, OFS_EFFECT, 0);
		chk(q, 32'(sel));
	endtask : boot
	task automatic final_report;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		bus(0, OFS_STRAP, 0);
		chk(q, 32'h1A);
		bus(0, 4'h2, 0);
		chk(q, UNMAPPED_READ);
		bus(0, OFS_ID, 0);
		chk(q, BLOCK_ID);
		$display("reset test done");
		boot(5'h00, 5'h1F);
		for (int i = 0; i < 12; i++)
			boot(5'($random(seed)), 5'($random(seed)));
		$display("strap test done");
		bus(1, OFS_OVR, 32'h1F);
		repeat (2) @(posedge clk);
		chk({v18, si, so, lg}, {3'h7, s[POS_LOG]});
		bus(1, OFS_OVR, 32'h05);
		repeat (2) @(posedge clk);
		chk({v18, si, so}, 0);
		$display("override test done");
		final_report();
	end
	initial begin
		#250000;
		fails++;
		final_report();
	end
endmodule : testbench
